// ### core/loopback_checker_consts.svh
`ifndef LOOPBACK_CHECKER_CONSTS_SVH
`define LOOPBACK_CHECKER_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_PKT_COUNT    8'h08
`define CTRL_RESET       5'h00

// ****************************************
// field positions
// ****************************************
`define CTRL_RESTART     0
`define CTRL_TX_FC       1
`define CTRL_RX_FC       2
`define CTRL_PTP_1STEP   3
`define CTRL_KEEP_FCS    4
`define STAT_STATE_LSB   8

// ****************************************
// packet layout and counts
// ****************************************
`define PKT_BYTES        522
`define SEG_BYTES        16
`define PTP_PKTS         3
`define DEF_NUM_PKTS     16
`define CRC_DEPTH        16
`define PAUSE_ALL        9'h1FF

`endif

// ### core/loopback_checker_pkg.sv
package loopback_checker_pkg;

    // one segment of the receive bus, first byte in the top lane
    typedef struct packed {
        logic         ena;
        logic         sop;
        logic         eop;
        logic         err;
        logic [3:0]   mty;
        logic [127:0] data;
    } rx_seg_t;

    // receive pause acceptance controls toward the mac
    typedef struct packed {
        logic       check_gcp;
        logic       check_ppp;
        logic [8:0] pause_enable;
    } pause_ctl_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_XCVR_LOCKED,
        ST_ALIGN_WAIT,
        ST_XFER_INIT,
        ST_RX_ENABLE,
        ST_RX_DONE,
        ST_PTP_RX,
        ST_PTP_DONE,
        ST_RESTART_WAIT
    } state_t;

endpackage

// ### core/crc_table.sv
`timescale 1ns/1ps

module crc_table #(
    parameter int                DEPTH  = 16,
    parameter int                AW     = 4,
    parameter logic [DEPTH*32-1:0] VALUES = '0
) (
    // clock
    input  wire logic          i_core_clk,
    // lookup
    input  wire logic [AW-1:0] i_addr,
    output logic      [31:0]   o_crc
);

    // registered read so the value is steady before the last word arrives
    always_ff @(posedge i_core_clk) begin
        o_crc <= VALUES[32*i_addr +: 32];
    end

endmodule

// ### core/loopback_checker.sv
`timescale 1ns/1ps
`include "loopback_checker_consts.svh"

module loopback_checker #(
    parameter int                       NUM_PKTS   = `DEF_NUM_PKTS,
    parameter int                       CRC_DEPTH  = `CRC_DEPTH,
    parameter logic [CRC_DEPTH*32-1:0]  CRC_VALUES = '0
) (
    // clock and reset
    input  wire logic                            i_core_clk,
    input  wire logic                            i_arst_n,
    // wishbone slave
    input  wire logic                            i_wb_cyc,
    input  wire logic                            i_wb_stb,
    input  wire logic                            i_wb_we,
    input  wire logic [7:0]                      i_wb_adr,
    input  wire logic [3:0]                      i_wb_sel,
    input  wire logic [31:0]                     i_wb_dat,
    output logic      [31:0]                     o_wb_dat,
    output logic                                 o_wb_ack,
    // mac status and test handshakes
    input  wire logic                            i_xcvr_reset_done,
    input  wire logic                            i_rx_aligned,
    input  wire logic                            i_pause_test_done,
    // receive bus
    input  wire loopback_checker_pkg::rx_seg_t   i_rx,
    input  wire logic [79:0]                     i_rx_ptp_tstamp,
    // mac controls
    output logic                                 o_ctl_rx_enable,
    output loopback_checker_pkg::pause_ctl_t     o_pause_ctl,
    // indicators
    output logic                                 o_xcvr_lock_indicator,
    output logic                                 o_rx_busy,
    output logic                                 o_rx_aligned_ind,
    output logic                                 o_rx_done,
    output logic                                 o_rx_data_fail,
    output logic                                 o_ptp_done,
    output logic      [79:0]                     o_ptp_tstamp
);
    import loopback_checker_pkg::*;

    localparam int          CRC_AW    = $clog2(CRC_DEPTH);
    localparam logic [7:0]  LAST_WORD = 8'((`PKT_BYTES - 1) / `SEG_BYTES);
    localparam int          MTY_INT   = (LAST_WORD + 1) * `SEG_BYTES - `PKT_BYTES;
    localparam logic [3:0]  LAST_MTY  = 4'(MTY_INT);
    localparam logic [127:0] MASK_LAST = {128{1'b1}} << (8 * MTY_INT);
    localparam logic [127:0] MASK_CRC  = MASK_LAST & ~(128'(32'hFFFF_FFFF) << (8 * MTY_INT));

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    logic       rst_meta_ff;
    logic       rst_n_ff;
    logic       done_meta_ff;
    logic       done_sync_ff;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // reset-done comes from the transceiver reset logic, not our clock
    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            done_meta_ff <= 1'b0;
            done_sync_ff <= 1'b0;
        end else begin
            done_meta_ff <= i_xcvr_reset_done;
            done_sync_ff <= done_meta_ff;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [4:0]  ctrl_ff;
    logic        restart_q_ff;
    logic [15:0] pkt_cnt_ff;
    logic [1:0]  ptp_cnt_ff;
    state_t      state_ff;
    logic        wb_req;
    logic        restart;
    logic        restart_rise;
    logic        both_fc;

    assign wb_req       = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign restart      = ctrl_ff[`CTRL_RESTART];
    assign restart_rise = restart & ~restart_q_ff;
    assign both_fc      = ctrl_ff[`CTRL_TX_FC] & ctrl_ff[`CTRL_RX_FC];

    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
            ctrl_ff  <= `CTRL_RESET;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= 32'h0000_0000;
            if (i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_adr == `REG_CTRL && i_wb_sel[0]) begin
                ctrl_ff <= i_wb_dat[4:0];
            end
            if (wb_req && !i_wb_we) begin
                case (i_wb_adr)
                    `REG_CTRL:      o_wb_dat <= {27'h0, ctrl_ff};
                    `REG_STATUS:    o_wb_dat <= {20'h0, 4'(state_ff), 2'h0, o_ptp_done,
                                                 o_rx_data_fail, o_rx_done, o_rx_aligned_ind,
                                                 o_rx_busy, o_xcvr_lock_indicator};
                    `REG_PKT_COUNT: o_wb_dat <= {14'h0, ptp_cnt_ff, pkt_cnt_ff};
                    default:        o_wb_dat <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            restart_q_ff <= 1'b0;
        end else begin
            restart_q_ff <= restart;
        end
    end

    // ****************************************
    // packet comparison
    // ****************************************
    logic [7:0]   word_ff;
    logic [31:0]  crc_exp;
    logic [127:0] exp_word;
    logic [127:0] mask;
    logic         last;
    logic         keep_fcs;
    logic         mismatch;
    logic         pkt_end;
    logic         run;

    assign keep_fcs = ctrl_ff[`CTRL_KEEP_FCS];
    assign pkt_end  = i_rx.ena & i_rx.eop;
    assign run      = i_rx_aligned;

    crc_table #(
        .DEPTH  (CRC_DEPTH),
        .AW     (CRC_AW),
        .VALUES (CRC_VALUES)
    ) u_crc (
        .i_core_clk (i_core_clk),
        .i_addr     (pkt_cnt_ff[CRC_AW-1:0]),
        .o_crc      (crc_exp)
    );

    // each word repeats its index in every byte lane
    always_comb begin
        exp_word = {16{word_ff}};
        last     = (word_ff == LAST_WORD);
        mask     = last ? (keep_fcs ? MASK_CRC : MASK_LAST) : {128{1'b1}};
        mismatch = 1'b0;
        if (i_rx.ena) begin
            if (i_rx.err || (i_rx.sop != (word_ff == 8'h00)) || (i_rx.eop != last)) begin
                mismatch = 1'b1;
            end
            if (i_rx.eop && i_rx.mty != LAST_MTY) begin
                mismatch = 1'b1;
            end
            if (((i_rx.data ^ exp_word) & mask) != 128'h0) begin
                mismatch = 1'b1;
            end
            if (last && keep_fcs && i_rx.data[8*MTY_INT +: 32] != crc_exp) begin
                mismatch = 1'b1;
            end
        end
    end

    // an early end of packet restarts the word count so later packets realign
    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            word_ff    <= 8'h00;
            pkt_cnt_ff <= 16'h0000;
        end else if (state_ff == ST_XFER_INIT || state_ff == ST_RX_DONE) begin
            word_ff    <= 8'h00;
            pkt_cnt_ff <= (state_ff == ST_XFER_INIT) ? 16'h0000 : pkt_cnt_ff;
        end else if (state_ff == ST_RX_ENABLE && i_rx.ena) begin
            word_ff    <= i_rx.eop ? 8'h00 : 8'(word_ff + 8'h01);
            pkt_cnt_ff <= i_rx.eop ? 16'(pkt_cnt_ff + 16'h0001) : pkt_cnt_ff;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ptp_cnt_ff   <= 2'h0;
            o_ptp_tstamp <= 80'h0;
        end else if (state_ff == ST_RX_DONE) begin
            ptp_cnt_ff <= 2'h0;
        end else if (state_ff == ST_PTP_RX && pkt_end) begin
            ptp_cnt_ff   <= 2'(ptp_cnt_ff + 2'h1);
            o_ptp_tstamp <= i_rx_ptp_tstamp;
        end
    end

    // ****************************************
    // control state machine
    // ****************************************
    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= ST_IDLE;
        end else if (!run && state_ff > ST_ALIGN_WAIT) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE:        if (done_sync_ff) state_ff <= ST_XCVR_LOCKED;
                ST_XCVR_LOCKED: state_ff <= ST_ALIGN_WAIT;
                ST_ALIGN_WAIT:  if (run) state_ff <= ST_XFER_INIT;
                ST_XFER_INIT:   state_ff <= ST_RX_ENABLE;
                ST_RX_ENABLE: begin
                    if (pkt_end && pkt_cnt_ff == 16'(NUM_PKTS - 1)) begin
                        state_ff <= ST_RX_DONE;
                    end
                end
                ST_RX_DONE: begin
                    if (ctrl_ff[`CTRL_PTP_1STEP]) begin
                        state_ff <= ST_PTP_RX;
                    end else if (!both_fc || i_pause_test_done) begin
                        state_ff <= ST_RESTART_WAIT;
                    end
                end
                ST_PTP_RX: begin
                    if (pkt_end && ptp_cnt_ff == 2'(`PTP_PKTS - 1)) begin
                        state_ff <= ST_PTP_DONE;
                    end
                end
                ST_PTP_DONE: begin
                    if (!both_fc || i_pause_test_done) begin
                        state_ff <= ST_RESTART_WAIT;
                    end
                end
                ST_RESTART_WAIT: if (restart_rise && run) state_ff <= ST_XFER_INIT;
                default:        state_ff <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // indicators and mac controls
    // ****************************************
    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_xcvr_lock_indicator <= 1'b0;
            o_ctl_rx_enable       <= 1'b0;
            o_rx_busy             <= 1'b0;
            o_rx_aligned_ind      <= 1'b0;
            o_rx_done             <= 1'b0;
            o_ptp_done            <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    o_xcvr_lock_indicator <= 1'b0;
                    o_ctl_rx_enable       <= 1'b0;
                    o_rx_busy             <= 1'b0;
                    o_rx_aligned_ind      <= 1'b0;
                end
                ST_XCVR_LOCKED: begin
                    o_xcvr_lock_indicator <= 1'b1;
                    o_ctl_rx_enable       <= 1'b1;
                    o_rx_busy             <= 1'b1;
                end
                ST_XFER_INIT: begin
                    o_rx_aligned_ind <= 1'b1;
                    o_rx_busy        <= 1'b1;
                    o_rx_done        <= 1'b0;
                    o_ptp_done       <= 1'b0;
                end
                ST_RX_DONE:      o_rx_done  <= 1'b1;
                ST_PTP_DONE:     o_ptp_done <= 1'b1;
                ST_RESTART_WAIT: o_rx_busy  <= 1'b0;
                default:         o_rx_busy  <= o_rx_busy;
            endcase
        end
    end

    // a mismatch in the same cycle as restart still sets the flag
    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_rx_data_fail <= 1'b0;
        end else if (state_ff == ST_RX_ENABLE && mismatch) begin
            o_rx_data_fail <= 1'b1;
        end else if (restart) begin
            o_rx_data_fail <= 1'b0;
        end
    end

    // acceptance is loaded from the control bit at lock and again at each transfer init
    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_pause_ctl <= '0;
        end else if (state_ff == ST_XCVR_LOCKED || state_ff == ST_XFER_INIT) begin
            o_pause_ctl.check_gcp    <= ctrl_ff[`CTRL_RX_FC];
            o_pause_ctl.check_ppp    <= ctrl_ff[`CTRL_RX_FC];
            o_pause_ctl.pause_enable <= ctrl_ff[`CTRL_RX_FC] ? `PAUSE_ALL : 9'h000;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n_ff);

    idle_exit_a: assert property (state_ff == ST_IDLE && done_sync_ff |=> state_ff == ST_XCVR_LOCKED)
        else $error("idle did not leave on reset done");
    lock_outputs_a: assert property (state_ff == ST_XCVR_LOCKED
        |=> o_xcvr_lock_indicator && o_rx_busy && o_ctl_rx_enable && state_ff == ST_ALIGN_WAIT)
        else $error("locked state outputs wrong");
    align_wait_a: assert property (state_ff == ST_ALIGN_WAIT
        |=> state_ff == ($past(run) ? ST_XFER_INIT : ST_ALIGN_WAIT))
        else $error("alignment wait misbehaved");
    init_flags_a: assert property (state_ff == ST_XFER_INIT && run
        |=> o_rx_aligned_ind && o_rx_busy && word_ff == 8'h00 && pkt_cnt_ff == 16'h0000 && state_ff == ST_RX_ENABLE)
        else $error("init did not prepare reception");
    fail_set_a: assert property (state_ff == ST_RX_ENABLE && mismatch |=> o_rx_data_fail)
        else $error("mismatch not flagged");
    fail_hold_a: assert property (o_rx_data_fail && !restart |=> o_rx_data_fail)
        else $error("data fail dropped without restart");
    done_entry_a: assert property (state_ff == ST_RX_ENABLE && run && pkt_end
        && pkt_cnt_ff == 16'(NUM_PKTS - 1) |=> state_ff == ST_RX_DONE ##1 o_rx_done)
        else $error("packet count did not end reception");
    pause_wait_a: assert property (state_ff == ST_RX_DONE && run && both_fc && !i_pause_test_done
        && !ctrl_ff[`CTRL_PTP_1STEP] |=> state_ff == ST_RX_DONE)
        else $error("left done before pause test");
    ptp_branch_a: assert property (state_ff == ST_RX_DONE && run && ctrl_ff[`CTRL_PTP_1STEP]
        |=> state_ff == ST_PTP_RX && ptp_cnt_ff == 2'h0)
        else $error("one step did not enter timing receive");
    ptp_done_a: assert property (state_ff == ST_PTP_DONE && run && !both_fc
        |=> state_ff == ST_RESTART_WAIT && o_ptp_done)
        else $error("timing done did not advance");
    restart_hold_a: assert property (state_ff == ST_RESTART_WAIT && run && !restart_rise
        |=> state_ff == ST_RESTART_WAIT && !o_rx_busy)
        else $error("restart wait left without edge");
    align_loss_a: assert property (state_ff > ST_ALIGN_WAIT && !run |=> state_ff == ST_IDLE)
        else $error("alignment loss not handled");
    pause_ctl_a: assert property (state_ff == ST_XFER_INIT && ctrl_ff[`CTRL_RX_FC]
        |=> o_pause_ctl.check_gcp && o_pause_ctl.check_ppp && o_pause_ctl.pause_enable == `PAUSE_ALL)
        else $error("pause acceptance not enabled");

endmodule

// ### verification/rx_mac_model.sv
`timescale 1ns/1ps

module rx_mac_model
    import loopback_checker_pkg::*;
(
    // control from the bench
    input  wire logic                          i_core_clk,
    input  wire logic                          i_go,
    input  wire logic [5:0]                    i_bad,
    input  wire logic [31:0]                   i_crc,
    // receive bus toward the checker
    output logic                               o_busy,
    output loopback_checker_pkg::rx_seg_t      o_rx
);
    import loopback_checker_pkg::*;

    // ****************************************
    // one 522 byte packet, 33 beats
    // ****************************************
    logic [5:0]   word_ff;
    logic [127:0] pat;

    initial begin
        o_busy  = 1'b0;
        o_rx    = '0;
        word_ff = 6'h00;
    end

    // every byte of word w carries w; i_bad flips one bit of that word
    assign pat = {16{2'h0, word_ff}} ^ {127'h0, word_ff == i_bad};

    always @(posedge i_core_clk) begin
        if (i_go) begin
            o_busy  <= 1'b1;
            word_ff <= 6'h00;
        end else if (o_busy) begin
            word_ff <= word_ff + 6'h01;
            o_busy  <= (word_ff != 6'h20);
        end
        if (o_busy && !i_go) begin
            // crc is whatever the bench supplies for this packet size
            o_rx <= '{ena: 1'b1, sop: word_ff == 6'h00, eop: word_ff == 6'h20, err: 1'b0,
                      mty: (word_ff == 6'h20) ? 4'h6 : 4'h0,
                      data: (word_ff == 6'h20) ? {pat[127:80], i_crc, pat[47:0]} : pat};
        end else begin
            // released bus keeps toggling so no stale beat looks valid
            o_rx <= '{ena: 1'b0, sop: 1'b0, eop: 1'b0, err: 1'b0, mty: 4'h0, data: ~o_rx.data};
        end
    end
endmodule

// ### verification/test_loopback_packet_checker.sv
`timescale 1ns/1ps
`include "loopback_checker_consts.svh"

module test_loopback_packet_checker;
    import loopback_checker_pkg::*;

    localparam int         NUM  = 2;
    localparam logic [511:0] CRCV = {{14{32'h0000_0000}}, 32'h1357_9BDF, 32'h2468_ACE0};

    logic clk, arst_n, cyc, stb, we, rdone, aligned, pdone, go, busy;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, crc;
    logic [5:0]  bad;
    logic [79:0] ts, ts_out;
    rx_seg_t     rx;
    logic        ack, rxen, lock, rbusy, alind, done, fail, pdn;
    pause_ctl_t  pctl;
    int          miscompares = 0;
    int          n_tests = 0;

    loopback_checker #(.NUM_PKTS(NUM), .CRC_VALUES(CRCV)) loopback_checker_i (
        .i_core_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_xcvr_reset_done(rdone), .i_rx_aligned(aligned), .i_pause_test_done(pdone),
        .i_rx(rx), .i_rx_ptp_tstamp(ts), .o_ctl_rx_enable(rxen), .o_pause_ctl(pctl),
        .o_xcvr_lock_indicator(lock), .o_rx_busy(rbusy), .o_rx_aligned_ind(alind),
        .o_rx_done(done), .o_rx_data_fail(fail), .o_ptp_done(pdn), .o_ptp_tstamp(ts_out));

    rx_mac_model rx_mac_model_i (.i_core_clk(clk), .i_go(go), .i_bad(bad), .i_crc(crc),
        .o_busy(busy), .o_rx(rx));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
        if (n >= 50) miscompares++;
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic rdst(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, `REG_STATUS, 32'h0, q);
        chk("status", {48'h0, e}, {48'h0, q & m});
    endtask

    task automatic send(input logic [5:0] b, input logic [31:0] c);
        int n;
        n = 0;
        @(posedge clk);
        bad <= b; crc <= c; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy === 1'b1 && ++n < 50);
    endtask

    // busy, done, data-fail and state code of a finished run
    function automatic logic [31:0] stat(input logic [3:0] s, input logic f);
        return {20'h0, s, 3'h0, f, 1'b1, 1'b0, s != 4'h8, 1'b0};
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    task automatic bring_up;
        logic [31:0] q;
        wb(1'b1, `REG_CTRL, 32'h14, q);
        rdst(32'h0F03, 32'h0);
        rdone <= 1'b1;
        repeat (8) @(posedge clk);
        rdst(32'h0F03, 32'h0203);
        chk("rx_enable", 80'h1, {79'h0, rxen});
        chk("lock", 80'h1, {79'h0, lock});
        aligned <= 1'b1;
        repeat (4) @(posedge clk);
        rdst(32'h0F07, 32'h0407);
        chk("pause_ctl", 80'h7FF, {69'h0, pctl});
    endtask

    // restart edge, NUM packets (the first may carry a bad word, every one a bad crc), optional timing packets
    task automatic run(input logic [4:0] c, input logic [5:0] b, input logic cb, input logic [3:0] s,
                       input logic f);
        logic [31:0] q;
        wb(1'b1, `REG_CTRL, {27'h0, c}, q);
        wb(1'b1, `REG_CTRL, {27'h0, c | 5'h01}, q);
        // restart back to 0, or a held restart would wipe a fresh data-fail
        wb(1'b1, `REG_CTRL, {27'h0, c}, q);
        // with the fcs stripped the last word is all payload
        for (int p = 0; p < NUM; p++) begin
            send((p == 0) ? b : 6'h3F, c[4] ? CRCV[p*32 +: 32] ^ {31'h0, cb} : 32'h2020_2020);
        end
        if (c[3]) begin
            rdst(32'h0F1A, stat(4'h6, f));
            for (int i = 1; i <= 3; i++) begin
                ts <= {16{5'(i)}};
                send(6'h3F, 32'h0);
            end
            repeat (4) @(posedge clk);
            chk("tstamp", {16{5'h03}}, ts_out);
            chk("ptp_done", 80'h1, {79'h0, pdn});
        end
        repeat (4) @(posedge clk);
        rdst(32'h0F1A, stat(s, f));
        if (s != 4'h8) begin
            pdone <= 1'b1;
            repeat (4) @(posedge clk);
            rdst(32'h0F1A, stat(4'h8, f));
            pdone <= 1'b0;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] q;
        arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
        rdone = 1'b0; aligned = 1'b0; pdone = 1'b0; go = 1'b0; bad = 6'h3F; crc = 32'h0; ts = 80'h0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bring_up();
        run(5'h14, 6'h3F, 1'b0, 4'h8, 1'b0);
        wb(1'b0, `REG_PKT_COUNT, 32'h0, q);
        chk("pkt_count", 80'(NUM), {64'h0, q[15:0]});
        run(5'h14, 6'h05, 1'b0, 4'h8, 1'b1);
        run(5'h14, 6'h3F, 1'b0, 4'h8, 1'b0);
        run(5'h14, 6'h3F, 1'b1, 4'h8, 1'b1);
        run(5'h06, 6'h3F, 1'b0, 4'h5, 1'b0);
        run(5'h0E, 6'h3F, 1'b0, 4'h7, 1'b0);
        run(5'h08, 6'h3F, 1'b0, 4'h8, 1'b0);
        aligned <= 1'b0;
        repeat (3) @(posedge clk);
        // idle clears the aligned indicator; reset-done still high walks back to alignment wait
        rdst(32'h0F04, 32'h0200);
        tally_and_finish();
    end
endmodule
